// [hw/chopper_pkg.sv]
// shared constants and carriers for the coil chopper
package chopper_pkg;

  // ****************************************
  // timing constants
  // ****************************************
  localparam logic [8:0] BLANK_CYC_0 = 9'h010; // 16 clocks
  localparam logic [8:0] BLANK_CYC_1 = 9'h018; // 24 clocks
  localparam logic [8:0] BLANK_CYC_2 = 9'h024; // 36 clocks
  localparam logic [8:0] BLANK_CYC_3 = 9'h036; // 54 clocks
  localparam logic [8:0] SLOW_BASE_CYC = 9'h018; // 24 clocks
  localparam int SLOW_STEP_SHIFT = 5; // 32 clocks per off-time unit
  localparam int FAST_STEP_SHIFT = 7; // 128 clocks per fast-decay unit

  // ****************************************
  // ranges and modes
  // ****************************************
  localparam logic [3:0] OFF_TIME_DISABLED = 4'h0;
  localparam logic MODE_FOUR_PHASE = 1'b0;
  localparam logic MODE_CONST_OFF = 1'b1;
  localparam logic signed [8:0] CORR_MAX = 9'sh0ff;
  localparam logic signed [8:0] CORR_MIN = -9'sh0ff;
  localparam logic [8:0] CORR_RESET = 9'h000;
  localparam logic [7:0] TUNED_RESET = 8'h00;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_ON = 3'b001,
    PH_SLOW1 = 3'b010,
    PH_FAST = 3'b011,
    PH_SLOW2 = 3'b100
  } phase_e;

  typedef struct packed {
    logic [3:0] off_time_setting;
    logic [1:0] blank_time_select;
    logic [3:0] fast_time_setting;
    logic mode_select;
  } chop_cfg_s;

  typedef struct packed {
    logic on_drive;
    logic fast_drive;
    logic slow_drive;
  } bridge_s;

endpackage

// [hw/coil_sequencer.sv]
// per-coil phase sequencer with blanking and timers
`timescale 1ns/1ps
`default_nettype none
module coil_sequencer (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // configuration
  input wire chopper_pkg::chop_cfg_s cfg,
  // synchronised comparator trip
  input wire logic comp_trip,
  // bridge drive and state
  output chopper_pkg::bridge_s bridge,
  output chopper_pkg::phase_e phase
);
  import chopper_pkg::*;

  phase_e phase_reg, phase_next;
  logic [8:0] blank_reg, blank_next;
  logic [11:0] timer_reg, timer_next;
  bridge_s bridge_reg;

  // ****************************************
  // decode
  // ****************************************
  // blank length by select code
  wire logic [8:0] blank_len = (cfg.blank_time_select == 2'h0) ? BLANK_CYC_0 :
                               (cfg.blank_time_select == 2'h1) ? BLANK_CYC_1 :
                               (cfg.blank_time_select == 2'h2) ? BLANK_CYC_2 : BLANK_CYC_3;
  // slow decay 24 + 32*off
  wire logic [11:0] slow_len = 12'({3'h0, SLOW_BASE_CYC}
                               + (12'(cfg.off_time_setting) << SLOW_STEP_SHIFT));
  // fast decay timer 128*(n+1), up to 2048 so the timer needs 12 bits
  wire logic [11:0] fast_len =
    12'((12'(cfg.fast_time_setting) + 12'h001) << FAST_STEP_SHIFT);
  wire logic enabled = cfg.off_time_setting != OFF_TIME_DISABLED;
  wire logic blanked = blank_reg != 9'h000;
  wire logic trip_ok = comp_trip && !blanked;
  wire logic timer_done = timer_reg == 12'h001;
  wire logic const_off = cfg.mode_select == MODE_CONST_OFF;

  // next-phase selection
  always_comb begin
    phase_next = phase_reg;
    blank_next = blanked ? blank_reg - 9'h001 : blank_reg;
    timer_next = (timer_reg != 12'h000) ? timer_reg - 12'h001 : timer_reg;
    case (phase_reg)
      PH_IDLE: begin
        if (enabled) begin
          phase_next = PH_ON;
          blank_next = blank_len;
        end
      end
      PH_ON: begin
        if (trip_ok) begin
          phase_next = const_off ? PH_FAST : PH_SLOW1;
          if (const_off) begin
            timer_next = fast_len;
            blank_next = blank_len;
          end else begin
            timer_next = slow_len;
          end
        end
      end
      PH_SLOW1: begin
        if (timer_done) begin
          phase_next = PH_FAST;
          timer_next = fast_len;
          blank_next = blank_len;
        end
      end
      PH_FAST: begin
        if (trip_ok || timer_done) begin
          phase_next = const_off ? PH_SLOW1 : PH_SLOW2;
          timer_next = slow_len;
        end
      end
      PH_SLOW2: begin
        if (timer_done) begin
          phase_next = PH_ON;
          blank_next = blank_len;
        end
      end
      default: phase_next = PH_IDLE;
    endcase
    // constant off-time: slow decay returns to on
    if (phase_reg == PH_SLOW1 && const_off && timer_done) begin
      phase_next = PH_ON;
      timer_next = 12'h000;
      blank_next = blank_len;
    end
    if (!enabled) begin
      phase_next = PH_IDLE;
      timer_next = 12'h000;
      blank_next = 9'h000;
    end
  end

  // state registers
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      phase_reg <= PH_IDLE;
      blank_reg <= 9'h000;
      timer_reg <= 11'h000;
      bridge_reg <= '0;
    end else begin
      phase_reg <= phase_next;
      blank_reg <= blank_next;
      timer_reg <= timer_next;
      bridge_reg.on_drive <= phase_next == PH_ON;
      bridge_reg.fast_drive <= phase_next == PH_FAST;
      bridge_reg.slow_drive <= phase_next == PH_SLOW1 || phase_next == PH_SLOW2;
    end
  end

  assign bridge = bridge_reg;
  assign phase = phase_reg;

  // ****************************************
  // assertions
  // ****************************************
  AST_OFF_IDLE: assert property (@(posedge clock) disable iff (!rst_b)
    !enabled |=> phase_reg == PH_IDLE) else $error("driver not off when off time zero");
  AST_SLOW_TIMER: assert property (@(posedge clock) disable iff (!rst_b)
    (phase_reg inside {PH_SLOW1, PH_SLOW2} && !timer_done && enabled)
    |=> phase_reg == $past(phase_reg)) else $error("slow decay left before timer");
  AST_ON_ENDS: assert property (@(posedge clock) disable iff (!rst_b)
    (phase_reg == PH_ON && trip_ok && enabled) |=> phase_reg != PH_ON) else $error("on phase not ended");
  AST_BLANK_MASK: assert property (@(posedge clock) disable iff (!rst_b)
    (phase_reg == PH_ON && blanked && enabled) |=> phase_reg == PH_ON) else $error("trip during blank");
  AST_FAST_END: assert property (@(posedge clock) disable iff (!rst_b)
    (phase_reg == PH_FAST && enabled && (timer_done || trip_ok))
    |=> phase_reg inside {PH_SLOW1, PH_SLOW2}) else $error("fast decay not ended");
  // on phase left in constant off-time mode
  sequence s_const_on_left;
    (const_off && phase_reg == PH_ON && enabled)
    ##1 (phase_reg != PH_ON && enabled && const_off);
  endsequence
  // fast decay left in four-phase mode
  sequence s_four_fast_left;
    (!const_off && phase_reg == PH_FAST && enabled)
    ##1 (phase_reg != PH_FAST && !const_off && enabled);
  endsequence
  AST_CONST_ORDER: assert property (@(posedge clock) disable iff (!rst_b)
    s_const_on_left |-> phase_reg == PH_FAST) else $error("const off order wrong");
  AST_FOUR_ORDER: assert property (@(posedge clock) disable iff (!rst_b)
    s_four_fast_left |-> phase_reg == PH_SLOW2) else $error("four phase order wrong");
  // the reset edge clears blank_reg instead of loading blank_len, so it is left out
  AST_BLANK_LEN: assert property (@(posedge clock) disable iff (!rst_b)
    (rst_b && enabled && phase_reg == PH_IDLE) |=> blank_reg == $past(blank_len))
    else $error("blank length wrong");
endmodule
`default_nettype wire

// [hw/coil_chopper_phase_control.sv]
// two-coil chopper top with pwm correction readback holding
`timescale 1ns/1ps
`default_nettype none
module coil_chopper_phase_control (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // configuration
  input wire chopper_pkg::chop_cfg_s cfg,
  input wire logic current_mode,
  // voltage regulator values
  input wire logic signed [8:0] regulator_correction,
  input wire logic [7:0] regulator_gradient,
  input wire logic [7:0] regulator_offset,
  // comparator pins per coil
  input wire logic [1:0] comp_pin,
  // bridge drive per coil
  output chopper_pkg::bridge_s [1:0] bridge,
  output chopper_pkg::phase_e [1:0] phase,
  output logic driver_enable,
  // readback
  output logic signed [8:0] correction_readback,
  output logic [7:0] tuned_gradient_readback,
  output logic [7:0] tuned_offset_readback
);
  import chopper_pkg::*;

  logic [1:0] comp_meta_reg;
  logic [1:0] comp_sync_reg;
  logic signed [8:0] corr_reg;
  logic [7:0] grad_reg;
  logic [7:0] ofs_reg;
  logic drv_reg;

  // ****************************************
  // comparator synchronisers
  // ****************************************
  // two flops per pin
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      comp_meta_reg <= 2'h0;
      comp_sync_reg <= 2'h0;
    end else begin
      comp_meta_reg <= comp_pin;
      comp_sync_reg <= comp_meta_reg;
    end
  end

  // ****************************************
  // one chopper per coil
  // ****************************************
  generate
    for (genvar c = 0; c < 2; c++) begin : g_coil
      coil_sequencer u_seq (
        .clock(clock),
        .rst_b(rst_b),
        .cfg(cfg),
        .comp_trip(comp_sync_reg[c]),
        .bridge(bridge[c]),
        .phase(phase[c])
      );
    end
  endgenerate

  // ****************************************
  // readback and enable
  // ****************************************
  // clamp correction to its range
  wire logic signed [8:0] corr_clamped =
    (regulator_correction < CORR_MIN) ? CORR_MIN : regulator_correction;

  // capture correction unless current chopper active; gradient and offset every cycle
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      corr_reg <= CORR_RESET;
      grad_reg <= TUNED_RESET;
      ofs_reg <= TUNED_RESET;
      drv_reg <= 1'b0;
    end else begin
      if (!current_mode) begin
        corr_reg <= corr_clamped;
      end
      grad_reg <= regulator_gradient;
      ofs_reg <= regulator_offset;
      drv_reg <= cfg.off_time_setting != OFF_TIME_DISABLED;
    end
  end

  assign correction_readback = corr_reg;
  assign tuned_gradient_readback = grad_reg;
  assign tuned_offset_readback = ofs_reg;
  assign driver_enable = drv_reg;

  // ****************************************
  // assertions
  // ****************************************
  AST_CORR_FROZEN: assert property (@(posedge clock) disable iff (!rst_b)
    current_mode |=> $stable(corr_reg)) else $error("correction moved in current mode");
  AST_CORR_RANGE: assert property (@(posedge clock) disable iff (!rst_b)
    corr_reg >= CORR_MIN && corr_reg <= CORR_MAX) else $error("correction out of range");
  // the reset edge clears the readback instead of loading it
  AST_GRAD_FOLLOW: assert property (@(posedge clock) disable iff (!rst_b)
    rst_b |=> grad_reg == $past(regulator_gradient)) else $error("gradient readback stale");
  AST_DRV_EN: assert property (@(posedge clock) disable iff (!rst_b)
    (cfg.off_time_setting == OFF_TIME_DISABLED) |=> !driver_enable)
    else $error("driver enabled at zero");
endmodule
`default_nettype wire

// [dv/coil_bridge_model.sv]
// behavioural bridge and sense comparator for one coil
`timescale 1ns/1ps
`default_nettype none
module coil_bridge_model #(
  parameter logic [7:0] TARGET = 8'h02
) (
  // clock
  input wire logic clock,
  // bridge drive from the chopper
  input wire chopper_pkg::bridge_s bridge,
  // hold comparator low during fast decay
  input wire logic quiet,
  // comparator output
  output logic comp
);
  import chopper_pkg::*;
  logic [7:0] level_reg = 8'h00;
  // current rises fast while driven, falls slowly in fast decay
  always_ff @(posedge clock) begin
    if (bridge.on_drive && level_reg < 8'hf0) begin
      level_reg <= level_reg + 8'h04;
    end else if (bridge.fast_drive && level_reg != 8'h00) begin
      level_reg <= level_reg - 8'h01;
    end
  end
  // high once coil current has reached target
  assign comp = (level_reg >= TARGET) && !(quiet && bridge.fast_drive);
endmodule
`default_nettype wire

// [dv/test_coil_chopper_phase_control.sv]
// self-checking bench for the two-coil chopper
`timescale 1ns/1ps
`default_nettype none
module test_coil_chopper_phase_control;
  import chopper_pkg::*;
  typedef struct packed {
    logic [3:0] off;
    logic cm;
    logic [8:0] corr;
    logic [7:0] grad;
    logic [7:0] ofs;
    logic en;
    logic [8:0] ecorr;
  } row_s;
  // ****************************************
  // signals
  // ****************************************
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  chop_cfg_s cfg = '0;
  logic current_mode = 1'b0;
  logic signed [8:0] regulator_correction = 9'h000;
  logic [7:0] regulator_gradient = 8'h00;
  logic [7:0] regulator_offset = 8'h00;
  wire logic [1:0] comp_pin;
  logic [1:0] quiet = 2'h0;
  bridge_s [1:0] bridge;
  phase_e [1:0] phase;
  logic driver_enable;
  logic signed [8:0] correction_readback;
  logic [7:0] tuned_gradient_readback;
  logic [7:0] tuned_offset_readback;
  int bad_count = 0;
  int n_checks = 0;
  int cycles = 0;
  int len;
  int bl_tab [4] = '{16, 24, 36, 54};
  row_s rows [4] = '{
    '{4'h0, 1'b0, 9'h100, 8'h00, 8'hff, 1'b0, 9'h101},
    '{4'h1, 1'b0, 9'h0ff, 8'ha5, 8'h5a, 1'b1, 9'h0ff},
    '{4'hf, 1'b1, 9'h010, 8'ha5, 8'h5a, 1'b1, 9'h0ff},
    '{4'h0, 1'b0, 9'h000, 8'h3c, 8'hc3, 1'b0, 9'h000}};
  // ****************************************
  // design, far side and clock
  // ****************************************
  coil_chopper_phase_control dut (.clock(clock), .rst_b(rst_b), .cfg(cfg),
    .current_mode(current_mode), .regulator_correction(regulator_correction),
    .regulator_gradient(regulator_gradient), .regulator_offset(regulator_offset),
    .comp_pin(comp_pin), .bridge(bridge), .phase(phase), .driver_enable(driver_enable),
    .correction_readback(correction_readback),
    .tuned_gradient_readback(tuned_gradient_readback),
    .tuned_offset_readback(tuned_offset_readback));
  coil_bridge_model #(.TARGET(8'h02)) coil0 (.clock(clock), .bridge(bridge[0]),
    .quiet(quiet[0]), .comp(comp_pin[0]));
  coil_bridge_model #(.TARGET(8'h28)) coil1 (.clock(clock), .bridge(bridge[1]),
    .quiet(quiet[1]), .comp(comp_pin[1]));
  always #4 clock = ~clock;
  // hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      final_report();
    end
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // count cycles a coil stays in its present phase
  task automatic measure(input int c);
    phase_e cur;
    cur = phase[c];
    chk(bridge[c], {cur == PH_ON, cur == PH_FAST, cur == PH_SLOW1 || cur == PH_SLOW2});
    len = 0;
    while (phase[c] === cur) begin
      len++;
      @(negedge clock);
    end
  endtask
  // follow one whole chopper cycle from a fresh on phase
  task automatic run_cycle(input int c, input logic m, input int bl, input int n);
    @(negedge clock);
    while (phase[c] === PH_ON) @(negedge clock);
    while (phase[c] !== PH_ON) @(negedge clock);
    measure(c);
    chk(len >= bl && len <= bl + 4, 1);
    if (m == MODE_FOUR_PHASE) begin
      chk(phase[c], PH_SLOW1);
      measure(c);
      chk(len, n);
      chk(phase[c], PH_FAST);
      measure(c);
      chk(len >= bl && len <= bl + 4, 1);
      chk(phase[c], PH_SLOW2);
      measure(c);
      chk(len, n);
    end else begin
      chk(phase[c], PH_FAST);
      measure(c);
      chk(len >= bl && len <= bl + 4, 1);
      chk(phase[c], PH_SLOW1);
      measure(c);
      chk(len, n);
    end
    chk(phase[c], PH_ON);
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (5) @(posedge clock);
    @(negedge clock);
    chk({driver_enable, phase, bridge}, 0);
    @(posedge clock) rst_b <= 1'b1;
    // readback and enable table
    foreach (rows[i]) begin
      @(posedge clock);
      cfg.off_time_setting <= rows[i].off;
      current_mode <= rows[i].cm;
      regulator_correction <= rows[i].corr;
      regulator_gradient <= rows[i].grad;
      regulator_offset <= rows[i].ofs;
      repeat (2) @(negedge clock);
      chk(driver_enable, rows[i].en);
      chk($unsigned(correction_readback), rows[i].ecorr);
      chk({tuned_gradient_readback, tuned_offset_readback}, {rows[i].grad, rows[i].ofs});
    end
    // every blank code in four-phase mode
    for (int t = 0; t < 4; t++) begin
      @(posedge clock) cfg <= '{4'h1, t[1:0], 4'h0, MODE_FOUR_PHASE};
      run_cycle(0, MODE_FOUR_PHASE, bl_tab[t], 56);
    end
    // constant off-time on both coils
    @(posedge clock) cfg <= '{4'h2, 2'h1, 4'h3, MODE_CONST_OFF};
    run_cycle(0, MODE_CONST_OFF, 24, 88);
    run_cycle(1, MODE_CONST_OFF, 24, 88);
    // fast decay ended by its timer while the comparator stays low: 128 * (15 + 1)
    @(posedge clock);
    cfg <= '{4'h1, 2'h0, 4'hf, MODE_CONST_OFF};
    quiet <= 2'h1;
    @(negedge clock);
    while (phase[0] === PH_FAST) @(negedge clock);
    while (phase[0] !== PH_FAST) @(negedge clock);
    measure(0);
    chk(len, 2048);
    chk(phase[0], PH_SLOW1);
    // reset in mid-run, then restart from idle
    @(posedge clock) rst_b <= 1'b0;
    repeat (2) @(negedge clock);
    chk({driver_enable, phase, bridge}, 0);
    @(posedge clock) rst_b <= 1'b1;
    @(negedge clock);
    chk(phase[0], PH_IDLE);
    @(negedge clock);
    chk({driver_enable, phase[0]}, {1'b1, PH_ON});
    // driver off returns both coils to idle
    @(posedge clock) cfg <= '{4'h0, 2'h1, 4'h3, MODE_CONST_OFF};
    repeat (2) @(negedge clock);
    chk({driver_enable, phase, bridge}, 0);
    final_report();
  end
endmodule
`default_nettype wire
